// [inc/spbcl_consts.vh]
/*
  Constants of the strap latch: strap bit positions, pull defaults,
  mode encodings and reset values.
  Assumes it is included by bare name from the design files.
*/
`ifndef SPBCL_CONSTS_VH
`define SPBCL_CONSTS_VH

// ----------------------------------------
// Strap bit positions in the strap value
// ----------------------------------------
`define SPBCL_BIT_LDO      0
`define SPBCL_BIT_BOOT     1
`define SPBCL_BIT_QUAL     2
`define SPBCL_BIT_LOG      3
`define SPBCL_BIT_SDIO     4
`define SPBCL_NSTRAP       5

// ----------------------------------------
// Internal pull directions, 1 = pull-up
// ----------------------------------------
`define SPBCL_PULL_UP_MASK 5'h1a

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define SPBCL_STRAP_RST    5'h1a
`define SPBCL_PULL_ALL     5'h1f
`define SPBCL_PULL_NONE    5'h00
`define SPBCL_RST_SYNC_INIT 3'h7
`define SPBCL_LOG_ON       1'b1
`define SPBCL_VSEL_3V3     1'b0
`define SPBCL_VSEL_1V8     1'b1
`define SPBCL_BOOT_FLASH   2'h1
`define SPBCL_BOOT_DNLD    2'h2
`define SPBCL_BOOT_UNDEF   2'h0
`define SPBCL_EDGE_FALL    1'b0
`define SPBCL_EDGE_RISE    1'b1

`endif

// [src/spbcl_sync3.v]
/*
  Three-stage synchroniser with agreement filter for the strap pins.
  Assumes inputs are asynchronous pins; one clock clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module spbcl_sync3 #(
  parameter W = 5
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         srst_i,
  // Pins in, filtered level out
  input  wire [W-1:0] async_i,
  input  wire [W-1:0] init_i,
  output reg  [W-1:0] level_o
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // ----------------------------------------
  // Stages; only the second reads the first
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    s1_r <= async_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // A change counts only once stages two and three agree
  always @(posedge clk_i)
  begin
    if (srst_i)
      level_o <= init_i;
    else
      level_o <= (s2_r & s3_r) | (level_o & (s2_r | s3_r));
  end

endmodule // spbcl_sync3

`default_nettype wire

// [src/spbcl_strap_latch.v]
/*
  Strap pin boot configuration latch: samples five strap pins at reset
  release, holds them until power-down, decodes boot settings.
  Assumes pins arrive asynchronously; the pad resolves pull enables and
  external drive into the *_i level; sys_rst_i is the system reset request.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spbcl_consts.vh"

// What this block does
// - Capture the five strap levels when system reset is released.
// - Hold captured bits until power-down, ignoring later pin activity.
// - Enable each strap pin's internal weak pull while reset is held.
// - Pulls set floating levels: voltage and qualifier low, others high.
// - After release, strap pins act as ordinary function pins.
// - Expose all five latched bits as a readable strap value.
// - Voltage strap 0 selects 3.3 V flash supply, 1 selects 1.8 V.
// - Boot select 1 means flash boot; 0 with qualifier 0 is download.
// - Log strap 0 silences boot log on primary serial transmit.
// - Log and SDIO straps pick SDIO sample and output edges.
// - Firmware bits may override flash voltage and SDIO edge timing.
module spbcl_strap_latch (
  // Clock and reset
  input  wire       clk_i,
  input  wire       srst_i,
  // System reset request and module enable
  input  wire       sys_rst_i,
  input  wire       module_en_i,
  // Strap pin levels
  input  wire       ldo_voltage_strap_i,
  input  wire       boot_select_strap_i,
  input  wire       download_qualifier_strap_i,
  input  wire       log_timing_strap_i,
  input  wire       sdio_edge_strap_i,
  // Pull control to pads
  output wire [4:0] pull_en_o,
  output wire [4:0] pull_up_o,
  output wire       strap_func_mode_o,
  // Firmware overrides
  input  wire       vsel_ovr_en_i,
  input  wire       vsel_ovr_val_i,
  input  wire       sdio_ovr_en_i,
  input  wire       sdio_ovr_sample_i,
  input  wire       sdio_ovr_output_i,
  // Status
  output reg  [4:0] strap_value_o,
  output reg        strap_valid_o,
  output reg        flash_vsel_1v8_o,
  output reg  [1:0] boot_mode_o,
  output reg        boot_log_en_o,
  output reg        sdio_sample_rise_o,
  output reg        sdio_output_rise_o
);

  // ----------------------------------------
  // Reset state
  // ----------------------------------------
  // Module enable low holds the chip in reset as well
  wire in_reset = sys_rst_i | ~module_en_i;

  wire [4:0] pins = {sdio_edge_strap_i, log_timing_strap_i,
                     download_qualifier_strap_i, boot_select_strap_i,
                     ldo_voltage_strap_i};
  wire [4:0] pins_s;

  spbcl_sync3 #(
    .W (`SPBCL_NSTRAP)
  ) u_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .async_i (pins),
    .init_i  (`SPBCL_STRAP_RST),
    .level_o (pins_s)
  );

  reg [2:0] rst_sh_r;
  reg       in_rst_r;

  // Reset request passes the same three stages with agreement
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rst_sh_r <= `SPBCL_RST_SYNC_INIT;
      in_rst_r <= 1'b1;
    end
    else
    begin
      rst_sh_r <= {rst_sh_r[1:0], in_reset};
      if (rst_sh_r[1] == rst_sh_r[2])
        in_rst_r <= rst_sh_r[2];
    end
  end

  // Pulls apply only while reset holds, fixing floating levels
  assign pull_en_o         = in_rst_r ? `SPBCL_PULL_ALL
                                      : `SPBCL_PULL_NONE;
  assign pull_up_o         = `SPBCL_PULL_UP_MASK;
  assign strap_func_mode_o = ~in_rst_r;

  // ----------------------------------------
  // Capture sequencing
  // ----------------------------------------
  // Armed waits for the first release after power-up; held never
  // leaves, so later watchdog or brownout releases do not recapture.
  localparam [1:0] ST_ARMED = 2'h0;
  localparam [1:0] ST_HELD  = 2'h1;

  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg        capture_nxt;

  // Release counts once stages two and three both show it; the pins
  // are still pulled at that edge, so a floating pin reads its default
  wire       release_seen = ~rst_sh_r[1] & ~rst_sh_r[2];

  always @*
  begin
    state_nxt   = state_r;
    capture_nxt = 1'b0;
    case (state_r)
      ST_ARMED:
      begin
        if (in_rst_r && release_seen)
        begin
          state_nxt   = ST_HELD;
          capture_nxt = 1'b1;
        end
      end
      ST_HELD:
        state_nxt = ST_HELD;
      default:
        state_nxt = ST_ARMED;
    endcase
  end

  // ----------------------------------------
  // Capture at release, hold to power-down
  // ----------------------------------------
  // Only srst_i (power loss) clears the latch; no write path exists,
  // so the strap value cannot be altered by software.
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_r       <= ST_ARMED;
      strap_value_o <= `SPBCL_STRAP_RST;
      strap_valid_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (capture_nxt)
      begin
        strap_value_o <= pins_s;
        strap_valid_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Firmware value wins whenever its enable is set; one helper serves
  // the supply select and both SDIO edges alike
  function ovr_pick;
    input ovr_en;
    input ovr_val;
    input strap_bit;
    begin
      ovr_pick = ovr_en ? ovr_val : strap_bit;
    end
  endfunction

  // Boot select low with qualifier high has no defined boot source
  function [1:0] boot_decode;
    input boot_sel;
    input qual;
    begin
      if (boot_sel)
        boot_decode = `SPBCL_BOOT_FLASH;
      else if (!qual)
        boot_decode = `SPBCL_BOOT_DNLD;
      else
        boot_decode = `SPBCL_BOOT_UNDEF;
    end
  endfunction

  // ----------------------------------------
  // Decode with firmware overrides
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      flash_vsel_1v8_o   <= `SPBCL_VSEL_3V3;
      boot_mode_o        <= `SPBCL_BOOT_FLASH;
      boot_log_en_o      <= `SPBCL_LOG_ON;
      sdio_sample_rise_o <= `SPBCL_EDGE_RISE;
      sdio_output_rise_o <= `SPBCL_EDGE_RISE;
    end
    else
    begin
      flash_vsel_1v8_o   <= ovr_pick(vsel_ovr_en_i, vsel_ovr_val_i,
                              strap_value_o[`SPBCL_BIT_LDO]);
      boot_mode_o        <= boot_decode(strap_value_o[`SPBCL_BIT_BOOT],
                              strap_value_o[`SPBCL_BIT_QUAL]);
      boot_log_en_o      <= strap_value_o[`SPBCL_BIT_LOG];
      sdio_sample_rise_o <= ovr_pick(sdio_ovr_en_i, sdio_ovr_sample_i,
                              strap_value_o[`SPBCL_BIT_LOG]);
      sdio_output_rise_o <= ovr_pick(sdio_ovr_en_i, sdio_ovr_output_i,
                              strap_value_o[`SPBCL_BIT_SDIO]);
    end
  end

endmodule // spbcl_strap_latch

`default_nettype wire

// [verif/spbcl_pins.sv]
/* Board side of the strap pins: host drive, else the pad pulls.
   Assumes pull controls come from the latch. */
`timescale 1ns/1ps
`default_nettype none
module spbcl_pins (
  // Drive and pulls in, pin levels out
  input  wire logic [4:0] drv_en_i, drv_val_i, pull_en_i, pull_up_i,
  output wire logic [4:0] level_o
);
  // Undriven and unpulled shows the inverse, so a stale level never passes
  assign level_o = (drv_en_i & drv_val_i)
                 | (~drv_en_i & pull_en_i & pull_up_i)
                 | (~drv_en_i & ~pull_en_i & ~drv_val_i);
endmodule // spbcl_pins
`default_nettype wire

// [verif/spbcl_checker.sv]
/* Checker of the strap latch outputs.
   Assumes it is bound to spbcl_strap_latch, one clock clk_i. */
`timescale 1ns/1ps
`default_nettype none
module spbcl_chk (
  input wire logic       clk_i, srst_i, sys_rst_i, module_en_i,
  input wire logic       vsel_ovr_en_i, vsel_ovr_val_i, sdio_ovr_en_i,
  input wire logic       sdio_ovr_sample_i, sdio_ovr_output_i,
  input wire logic [4:0] pull_en_o, pull_up_o, strap_value_o,
  input wire logic       strap_valid_o, flash_vsel_1v8_o, boot_log_en_o,
  input wire logic [1:0] boot_mode_o,
  input wire logic       sdio_sample_rise_o, sdio_output_rise_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ----------------
  // Capture and decode
  // ----------------
  sequence s_rel;
    $fell(sys_rst_i) && module_en_i && !strap_valid_o;
  endsequence
  sequence s_dec;
    $past(strap_valid_o);
  endsequence
  a_capture_time: assert property (
    s_rel |-> ##[1:8] strap_valid_o) else $error("no capture");
  a_hold_value: assert property (
    strap_valid_o |=> strap_valid_o && $stable(strap_value_o))
    else $error("strap changed");
  a_pull_reset: assert property (
    !strap_valid_o |-> pull_en_o == 5'h1f) else $error("pulls off");
  a_pull_dir: assert property (
    pull_up_o == 5'h1a) else $error("pull direction");
  a_vsel_map: assert property (s_dec |-> flash_vsel_1v8_o ==
    ($past(vsel_ovr_en_i) ? $past(vsel_ovr_val_i) : strap_value_o[0]))
    else $error("vsel");
  a_boot_map: assert property (s_dec |-> boot_mode_o ==
    (strap_value_o[1] ? 2'h1 : {~strap_value_o[2], 1'b0}))
    else $error("boot mode");
  a_log_map: assert property (
    s_dec |-> boot_log_en_o == strap_value_o[3]) else $error("log");
  a_sdio_map: assert property (s_dec |->
    {sdio_sample_rise_o, sdio_output_rise_o} == ($past(sdio_ovr_en_i) ?
    {$past(sdio_ovr_sample_i), $past(sdio_ovr_output_i)} :
    {strap_value_o[3], strap_value_o[4]})) else $error("sdio edges");
endmodule // spbcl_chk
bind spbcl_strap_latch spbcl_chk u_chk (.*);
`default_nettype wire

// [verif/tb_top.sv]
/* Testbench: boots the strap latch with several pin patterns.
   Assumes the pin model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_i = 0, srst_i = 1, sys_rst_i = 1, module_en_i = 0;
  logic [4:0] de = 0, dv = 0, pe, pu, sv, ovr = 0;
  logic       func, valid, vsel, log_en, smp, outr;
  logic [1:0] bm;
  wire  [4:0] lvl;
  int         n_mismatch = 0, tests_run = 0, k;
  always #2.5 clk_i = ~clk_i;
  spbcl_pins pins_u (.drv_en_i(de), .drv_val_i(dv), .pull_en_i(pe),
    .pull_up_i(pu), .level_o(lvl));
  spbcl_strap_latch dut_u (.clk_i, .srst_i, .sys_rst_i, .module_en_i,
    .ldo_voltage_strap_i(lvl[0]), .boot_select_strap_i(lvl[1]),
    .download_qualifier_strap_i(lvl[2]), .log_timing_strap_i(lvl[3]),
    .sdio_edge_strap_i(lvl[4]), .pull_en_o(pe), .pull_up_o(pu),
    .strap_func_mode_o(func), .vsel_ovr_en_i(ovr[4]),
    .vsel_ovr_val_i(ovr[3]), .sdio_ovr_en_i(ovr[2]),
    .sdio_ovr_sample_i(ovr[1]), .sdio_ovr_output_i(ovr[0]),
    .strap_value_o(sv), .strap_valid_o(valid), .flash_vsel_1v8_o(vsel),
    .boot_mode_o(bm), .boot_log_en_o(log_en),
    .sdio_sample_rise_o(smp), .sdio_output_rise_o(outr));
  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task chk(input logic [4:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------
  // Power-up with pins set, then check the decode
  // ----------------
  task boot(input logic [4:0] e, v);
    srst_i = 1;
    sys_rst_i = 1;
    de = e;
    dv = v;
    step(2);
    chk(pe, 5'h1f);
    srst_i = 0;
    step(5);
    sys_rst_i = 0;
    step(6);
    chk(valid, module_en_i);
    module_en_i = 1;
    for (k = 0; k < 20 && valid !== 1'b1; k++)
      step(1);
    if (k == 20)
    begin
      n_mismatch++;
      test_done;
    end
    step(2);
    v = (v & e) | (5'h1a & ~e);
    chk(sv, v);
    chk(vsel, v[0]);
    chk(bm, v[1] ? 2'h1 : {~v[2], 1'b0});
    chk(log_en, v[3]);
    chk({smp, outr}, {v[3], v[4]});
  endtask
  initial
  begin
    step(4);
    boot(5'h00, 5'h00);
    boot(5'h1f, 5'h00);
    boot(5'h1f, 5'h1f);
    boot(5'h1f, 5'h05);
    boot(5'h1f, 5'h10);
    boot(5'h1f, 5'h08);
    // A later reset with new pin levels must not recapture
    dv = 5'h17;
    sys_rst_i = 1;
    step(4);
    chk(pe, 5'h1f);
    chk(func, 1'b0);
    sys_rst_i = 0;
    step(8);
    chk(sv, 5'h08);
    chk({func, pe}, 6'h20);
    ovr = 5'h1c;
    step(2);
    chk({vsel, smp, outr}, 3'h4);
    test_done;
  end
endmodule // tb_top
`default_nettype wire
